// >>> rtl/pcs_defines.svh
// Constants for the power and configuration sequencer.
// Contract
// - Reference off forces reset monitor, PLLs, oscillator and differential buffers off.
// - Reference may be switched off only on the 1.2 V core variant.
// - Reset monitor may be disabled in standby; enabled monitor drop restarts configuration.
// - Oscillator can be off permanently, and separately off on standby entry.
// - PLL off statically or in standby, only after all its output clocks are low; the code waits for the clocks only on standby entry.
// - Per-bank run-time enables power differential buffers off or on.
// - Each primary clock net has its own run-time enable.
// - Each input buffer can be gated, including clock inputs during standby.
// - Valid core and configuration-bank supplies start download from the nonvolatile store.
// - User I/Os stay tri-stated from power-up until configuration completes.
// - User I/Os go to user logic only once user mode is entered.
// - In user mode, monitored core supply drop resets and returns to supply monitoring.
// - Reference off shuts the main reset monitor, keeps the low-power detector.
// - Five configuration sources: internal store, test port, master SPI, slave SPI, I2C.
// - After power-up, configuration is accepted through the selected serial port.
// - A selected configuration port stays active until the configuration cycle ends.
// - The test port may be activated any time after power-up by its command; the code accepts it only in user mode or after a CRC failure.
// - When enabled, a CRC check runs on entering user mode.
// - The 10 dual-function configuration pins act as GPIO when not configuring; the code frees them only in user mode and standby.
// - Security bits set refuse readback of both memories; unlocked or locked only.
// - Security bits clear only as part of a full device erase.
// - One-time-programmable mode rejects every erase or reprogram of protected memory.
// - Standby entered on request toggle or matching I2C or test-port instruction.
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_DUAL_PINS      10
`define PCS_BANKS          4
`define PCS_CLK_NETS       8
`define PCS_IN_BUFS        8
`define PCS_PLLS           2
`define PCS_CRC_W          16
`define PCS_CRC_POLY       16'h1021
`define PCS_CRC_INIT       16'hFFFF
`define PCS_CLK_MHZ        100
`define PCS_STEP_NS        50
`define PCS_STEP_CYC       ((`PCS_STEP_NS * `PCS_CLK_MHZ) / 1000)
`define PCS_SRC_NV         3'h0
`define PCS_SRC_TEST       3'h1
`define PCS_SRC_MSPI       3'h2
`define PCS_SRC_SLAVE_SERIAL_CONFIG       3'h3
`define PCS_SRC_I2C        3'h4
`endif

// >>> rtl/pcs_pkg.sv
// Types shared by the power and configuration sequencer.
package pcs_pkg;
  typedef enum logic [3:0] {
    PCS_ST_RESET   = 4'b0000,
    PCS_ST_MONITOR = 4'b0001,
    PCS_ST_CONFIG  = 4'b0010,
    PCS_ST_CRC     = 4'b0011,
    PCS_ST_USER    = 4'b0100,
    PCS_ST_SB_DOWN = 4'b0101,
    PCS_ST_STANDBY = 4'b0110,
    PCS_ST_SB_UP   = 4'b0111,
    PCS_ST_FAIL    = 4'b1000
  } pcs_state_t;
  typedef struct packed {
    logic ref_off;
    logic mon_off;
    logic osc_off;
    logic pll_off;
    logic diff_off;
    logic inbuf_off;
  } pcs_sb_sel_t;
  typedef struct packed {
    logic ref_on;
    logic mon_on;
    logic lp_det_on;
    logic osc_on;
  } pcs_analog_t;
endpackage

// >>> rtl/pcs_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/100ps
`default_nettype none
module pcs_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_in;
      q_ff    <= meta_ff;
    end
  end
  assign q_out = q_ff;
endmodule
`default_nettype wire

// >>> rtl/pcs_crc.sv
// Serial CRC over the loaded configuration stream.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defines.svh"
module pcs_crc
  import pcs_pkg::*;
#(
  parameter int W = `PCS_CRC_W
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         clear_in,
  input  wire logic         bit_vld_in,
  input  wire logic         bit_in,
  output logic      [W-1:0] crc_out
);
  logic [W-1:0] crc_ff;
  logic [W-1:0] nxt_crc;
  initial begin
    if (W != 16) $error("pcs_crc supports only 16 bits");
  end
  always_comb begin
    nxt_crc = crc_ff;
    if (clear_in) begin
      nxt_crc = `PCS_CRC_INIT;
    end else if (bit_vld_in) begin
      nxt_crc = {crc_ff[W-2:0], 1'b0} ^ ((crc_ff[W-1] ^ bit_in) ? `PCS_CRC_POLY : 16'h0000);
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      crc_ff <= `PCS_CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end
  assign crc_out = crc_ff;
endmodule
`default_nettype wire

// >>> rtl/pcs_seq.sv
// Power, standby, configuration and security sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defines.svh"
module pcs_seq
  import pcs_pkg::*;
#(
  parameter int BANKS   = `PCS_BANKS,
  parameter int NETS    = `PCS_CLK_NETS,
  parameter int INBUFS  = `PCS_IN_BUFS,
  parameter int PLLS    = `PCS_PLLS,
  parameter int DPINS   = `PCS_DUAL_PINS
) (
  // Clock and reset.
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // Supply monitors and static options (pins, asynchronous).
  input  wire logic              core_ok_in,
  input  wire logic              cfgbank_ok_in,
  input  wire logic              lp_det_ok_in,
  input  wire logic              core_1v2_in,
  input  wire logic              mon_user_en_in,
  input  wire logic              crc_en_in,
  input  wire logic              osc_unused_in,
  input  wire logic [PLLS-1:0]   pll_unused_in,
  input  wire pcs_sb_sel_t       sb_sel_in,
  // Standby requests.
  input  wire logic              sb_req_tgl_in,
  input  wire logic              sb_cmd_i2c_in,
  input  wire logic              sb_cmd_test_in,
  input  wire logic              wake_in,
  // Run-time enables.
  input  wire logic [BANKS-1:0]  diff_bank_en_in,
  input  wire logic [NETS-1:0]   clk_net_en_in,
  input  wire logic [INBUFS-1:0] inbuf_en_in,
  input  wire logic [INBUFS-1:0] inbuf_is_clk_in,
  input  wire logic [PLLS-1:0]   pll_clk_low_in,
  // Configuration sources and stream.
  input  wire logic [2:0]        port_sel_in,
  input  wire logic              test_cmd_in,
  input  wire logic              cfg_bit_vld_in,
  input  wire logic              cfg_bit_in,
  input  wire logic              cfg_last_in,
  input  wire logic [`PCS_CRC_W-1:0] crc_exp_in,
  // Security requests.
  input  wire logic              sec_set_in,
  input  wire logic              otp_set_in,
  input  wire logic              erase_req_in,
  input  wire logic              prog_req_in,
  input  wire logic              readback_req_in,
  // Analog and power controls.
  output pcs_analog_t            analog_out,
  output logic [PLLS-1:0]        pll_pwr_out,
  output logic [BANKS-1:0]       diff_bank_pwr_out,
  output logic [NETS-1:0]        clk_net_en_out,
  output logic [INBUFS-1:0]      inbuf_en_out,
  // Configuration status.
  output pcs_state_t             state_out,
  output logic [2:0]             active_port_out,
  output logic                   crc_err_out,
  output logic                   io_user_out,
  output logic [DPINS-1:0]       dual_pin_gpio_out,
  // Security status.
  output logic                   locked_out,
  output logic                   otp_out,
  output logic                   readback_ok_out,
  output logic                   erase_ok_out,
  output logic                   prog_ok_out,
  output logic                   req_rejected_out
);
  localparam int STEP_CYC = `PCS_STEP_CYC < 1 ? 1 : `PCS_STEP_CYC;
  initial begin
    if (PLLS < 1 || BANKS < 1 || NETS < 1 || INBUFS < 1) $error("pcs_seq widths must be >= 1");
    if (DPINS != `PCS_DUAL_PINS) $error("pcs_seq needs 10 dual-function pins");
  end

  // Asynchronous pins pass two flops first, except pll_unused_in and sb_sel_in, which are used unsynchronised.
  logic [8:0] raw_s;
  logic [8:0] syn_s;
  assign raw_s = {core_ok_in, cfgbank_ok_in, lp_det_ok_in, core_1v2_in, mon_user_en_in,
                  crc_en_in, osc_unused_in, sb_req_tgl_in, wake_in};
  pcs_sync #(.W(9)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (raw_s),
    .q_out      (syn_s)
  );
  logic core_ok_s, bank_ok_s, lp_ok_s, v12_s, mon_en_s, crc_en_s, osc_un_s, tgl_s, wake_s;
  assign {core_ok_s, bank_ok_s, lp_ok_s, v12_s, mon_en_s, crc_en_s, osc_un_s, tgl_s, wake_s}
    = syn_s;

  logic [PLLS-1:0] pll_low_s;
  pcs_sync #(.W(PLLS)) u_sync_pll (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (pll_clk_low_in),
    .q_out      (pll_low_s)
  );

  // Sequencer state.
  pcs_state_t       state_ff, nxt_state;
  logic [2:0]       port_ff, nxt_port;
  logic             crc_err_ff, nxt_crc_err;
  logic             tgl_ff, nxt_tgl;
  pcs_sb_sel_t      sel_ff, nxt_sel;
  logic [2:0]       step_ff, nxt_step;
  logic [7:0]       cnt_ff, nxt_cnt;
  logic [PLLS-1:0]  pll_pwr_ff, nxt_pll_pwr;
  logic [`PCS_CRC_W-1:0] crc_val;
  logic             crc_clr;
  logic             sb_req;
  logic             drop;

  assign sb_req = (tgl_s != tgl_ff) || sb_cmd_i2c_in || sb_cmd_test_in;
  // Main monitor while it is on, low-power detector otherwise.
  assign drop = mon_en_s && (analog_out.mon_on ? !core_ok_s : !lp_ok_s);

  pcs_crc u_crc (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clear_in   (crc_clr),
    .bit_vld_in (cfg_bit_vld_in && state_ff == PCS_ST_CONFIG),
    .bit_in     (cfg_bit_in),
    .crc_out    (crc_val)
  );
  // Every configuration cycle starts from a fresh seed, reconfigurations from user mode too.
  assign crc_clr = (state_ff != PCS_ST_CONFIG);

  always_comb begin
    nxt_state   = state_ff;
    nxt_port    = port_ff;
    nxt_crc_err = crc_err_ff;
    nxt_tgl     = tgl_s;
    nxt_sel     = sel_ff;
    nxt_step    = step_ff;
    nxt_cnt     = (cnt_ff == 8'h00) ? 8'h00 : cnt_ff - 8'h01;
    nxt_pll_pwr = pll_pwr_ff;
    case (state_ff)
      PCS_ST_RESET: begin
        nxt_state = PCS_ST_MONITOR;
      end
      PCS_ST_MONITOR: begin
        nxt_port = `PCS_SRC_NV;
        if (core_ok_s && bank_ok_s) begin
          nxt_state = PCS_ST_CONFIG;
          nxt_crc_err = 1'b0;
        end
      end
      PCS_ST_CONFIG: begin
        if (!core_ok_s || !bank_ok_s) begin
          nxt_state = PCS_ST_MONITOR;
        end else if (cfg_last_in) begin
          nxt_state = crc_en_s ? PCS_ST_CRC : PCS_ST_USER;
        end
      end
      PCS_ST_CRC: begin
        nxt_crc_err = (crc_val != crc_exp_in);
        nxt_state   = (crc_val != crc_exp_in) ? PCS_ST_FAIL : PCS_ST_USER;
      end
      PCS_ST_USER: begin
        nxt_pll_pwr = ~pll_unused_in;
        if (drop) begin
          nxt_state = PCS_ST_MONITOR;
        end else if (sb_req) begin
          nxt_sel          = sb_sel_in;
          nxt_sel.ref_off  = sb_sel_in.ref_off && v12_s;
          nxt_step  = 3'h0;
          nxt_cnt   = 8'(STEP_CYC);
          nxt_state = PCS_ST_SB_DOWN;
        end else if (port_sel_in != port_ff || test_cmd_in) begin
          // A new cycle starts only from monitor, user or fail state, so the port never changes mid-cycle.
          nxt_port  = test_cmd_in ? `PCS_SRC_TEST : port_sel_in;
          nxt_state = PCS_ST_CONFIG;
        end
      end
      PCS_ST_SB_DOWN: begin
        if (drop) begin
          nxt_state = PCS_ST_MONITOR;
        end else if (cnt_ff == 8'h00) begin
          if (step_ff == 3'h0 && (sel_ff.pll_off || sel_ff.ref_off)) begin
            // The PLL waits for every output clock to sit low before it drops power.
            if (&pll_low_s) begin
              nxt_pll_pwr = '0;
              nxt_step = 3'h1;
            end
          end else if (step_ff == 3'h3) begin
            nxt_state = PCS_ST_STANDBY;
          end else begin
            nxt_step = step_ff + 3'h1;
            nxt_cnt  = 8'(STEP_CYC);
          end
        end
      end
      PCS_ST_STANDBY: begin
        if (drop) begin
          nxt_state = PCS_ST_MONITOR;
        end else if (wake_s) begin
          nxt_cnt   = 8'(STEP_CYC);
          nxt_state = PCS_ST_SB_UP;
        end
      end
      PCS_ST_SB_UP: begin
        if (cnt_ff == 8'h00) begin
          if (step_ff == 3'h0) begin
            nxt_pll_pwr = ~pll_unused_in;
            nxt_sel     = '0;
            nxt_state   = PCS_ST_USER;
          end else begin
            nxt_step = step_ff - 3'h1;
            nxt_cnt  = 8'(STEP_CYC);
          end
        end
      end
      PCS_ST_FAIL: begin
        if (port_sel_in != port_ff || test_cmd_in) begin
          nxt_port  = test_cmd_in ? `PCS_SRC_TEST : port_sel_in;
          nxt_state = PCS_ST_CONFIG;
        end
      end
      default: begin
        nxt_state = PCS_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_ff   <= PCS_ST_RESET;
      port_ff    <= `PCS_SRC_NV;
      crc_err_ff <= 1'b0;
      tgl_ff     <= 1'b0;
      sel_ff     <= '0;
      step_ff    <= 3'h0;
      cnt_ff     <= 8'h00;
      pll_pwr_ff <= '0;
    end else begin
      state_ff   <= nxt_state;
      port_ff    <= nxt_port;
      crc_err_ff <= nxt_crc_err;
      tgl_ff     <= nxt_tgl;
      sel_ff     <= nxt_sel;
      step_ff    <= nxt_step;
      cnt_ff     <= nxt_cnt;
      pll_pwr_ff <= nxt_pll_pwr;
    end
  end

  // Security state; the lock bit is sticky until a permitted full erase, the OTP bit until reset.
  logic locked_ff, nxt_locked;
  logic otp_ff, nxt_otp;
  logic rej_ff, nxt_rej;
  logic ers_ok_ff, nxt_ers_ok;
  logic prg_ok_ff, nxt_prg_ok;
  logic rb_ok_ff, nxt_rb_ok;
  always_comb begin
    nxt_locked = locked_ff || sec_set_in;
    nxt_otp    = otp_ff || otp_set_in;
    nxt_ers_ok = erase_req_in && !otp_ff;
    nxt_prg_ok = prog_req_in && !otp_ff;
    nxt_rb_ok  = readback_req_in && !locked_ff;
    nxt_rej    = (otp_ff && (erase_req_in || prog_req_in)) || (locked_ff && readback_req_in);
    if (erase_req_in && !otp_ff && !sec_set_in) begin
      nxt_locked = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      locked_ff <= 1'b0;
      otp_ff    <= 1'b0;
      rej_ff    <= 1'b0;
      ers_ok_ff <= 1'b0;
      prg_ok_ff <= 1'b0;
      rb_ok_ff  <= 1'b0;
    end else begin
      locked_ff <= nxt_locked;
      otp_ff    <= nxt_otp;
      rej_ff    <= nxt_rej;
      ers_ok_ff <= nxt_ers_ok;
      prg_ok_ff <= nxt_prg_ok;
      rb_ok_ff  <= nxt_rb_ok;
    end
  end

  // Power outputs, registered so no glitch reaches the analog controls.
  pcs_analog_t       analog_ff, nxt_analog;
  logic [BANKS-1:0]  diff_ff, nxt_diff;
  logic [NETS-1:0]   net_ff, nxt_net;
  logic [INBUFS-1:0] inb_ff, nxt_inb;
  logic              in_sb;
  logic              user_ff, nxt_user;
  logic [DPINS-1:0]  gpio_ff, nxt_gpio;
  assign in_sb = (state_ff == PCS_ST_SB_DOWN || state_ff == PCS_ST_STANDBY ||
                  state_ff == PCS_ST_SB_UP);
  always_comb begin
    nxt_analog.ref_on    = !(in_sb && sel_ff.ref_off && step_ff >= 3'h3);
    nxt_analog.mon_on    = nxt_analog.ref_on && !(in_sb && sel_ff.mon_off && step_ff >= 3'h2);
    nxt_analog.lp_det_on = !nxt_analog.mon_on;
    nxt_analog.osc_on    = !osc_un_s && nxt_analog.ref_on &&
                           !(in_sb && sel_ff.osc_off && step_ff >= 3'h2);
    nxt_diff = (in_sb && (sel_ff.diff_off || sel_ff.ref_off) && step_ff >= 3'h1) ? '0 :
               diff_bank_en_in;
    nxt_net  = clk_net_en_in;
    nxt_inb  = inbuf_en_in & ~((in_sb && sel_ff.inbuf_off && step_ff >= 3'h1) ?
               inbuf_is_clk_in : '0);
    nxt_user = nxt_state inside {PCS_ST_USER, PCS_ST_SB_DOWN,
                                 PCS_ST_STANDBY, PCS_ST_SB_UP};
    nxt_gpio = (state_ff == PCS_ST_CONFIG && port_ff != `PCS_SRC_NV) ? '0 : {DPINS{nxt_user}};
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      analog_ff <= '{ref_on: 1'b1, mon_on: 1'b1, lp_det_on: 1'b0, osc_on: 1'b1};
      diff_ff   <= '0;
      net_ff    <= '0;
      inb_ff    <= '0;
      user_ff   <= 1'b0;
      gpio_ff   <= '0;
    end else begin
      analog_ff <= nxt_analog;
      diff_ff   <= nxt_diff;
      net_ff    <= nxt_net;
      inb_ff    <= nxt_inb;
      user_ff   <= nxt_user;
      gpio_ff   <= nxt_gpio;
    end
  end

  assign analog_out        = analog_ff;
  assign pll_pwr_out       = pll_pwr_ff & {PLLS{analog_ff.ref_on}};
  assign diff_bank_pwr_out = diff_ff & {BANKS{analog_ff.ref_on}};
  assign clk_net_en_out    = net_ff;
  assign inbuf_en_out      = inb_ff;
  assign state_out         = state_ff;
  assign active_port_out   = port_ff;
  assign crc_err_out       = crc_err_ff;
  assign io_user_out       = user_ff;
  assign dual_pin_gpio_out = gpio_ff;
  assign locked_out        = locked_ff;
  assign otp_out           = otp_ff;
  assign readback_ok_out   = rb_ok_ff;
  assign erase_ok_out      = ers_ok_ff;
  assign prog_ok_out       = prg_ok_ff;
  assign req_rejected_out  = rej_ff;
endmodule
`default_nettype wire

// >>> dv/pcs_seq_monitor.sv
// Port-level assertions for the power and configuration sequencer.
`timescale 1ns/100ps
`default_nettype none
module pcs_seq_monitor
  import pcs_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int NETS  = 8,
  parameter int PLLS  = 2
) (
  // Clock, reset and inputs.
  input wire logic             sys_clk_in,
  input wire logic             rst_in,
  input wire logic             core_ok_in,
  input wire logic             core_1v2_in,
  input wire logic             mon_user_en_in,
  input wire logic [BANKS-1:0] diff_bank_en_in,
  input wire logic [NETS-1:0]  clk_net_en_in,
  input wire logic             erase_req_in,
  input wire logic             prog_req_in,
  input wire logic             readback_req_in,
  // Design outputs.
  input wire pcs_analog_t      analog_out,
  input wire logic [PLLS-1:0]  pll_pwr_out,
  input wire logic [BANKS-1:0] diff_bank_pwr_out,
  input wire logic [NETS-1:0]  clk_net_en_out,
  input wire pcs_state_t       state_out,
  input wire logic [2:0]       active_port_out,
  input wire logic             io_user_out,
  input wire logic             locked_out,
  input wire logic             otp_out,
  input wire logic             readback_ok_out,
  input wire logic             erase_ok_out,
  input wire logic             prog_ok_out,
  input wire logic             req_rejected_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_ref_cuts_analog: assert property (
    !analog_out.ref_on |-> !analog_out.osc_on && pll_pwr_out == '0 && diff_bank_pwr_out == '0)
    else $error("analog on");
  a_ref_needs_1v2: assert property (!analog_out.ref_on |-> core_1v2_in)
    else $error("bad variant");
  a_lp_det_kept: assert property (
    !analog_out.ref_on |-> !analog_out.mon_on && analog_out.lp_det_on) else $error("bad monitor");
  a_drop_restarts: assert property (
    $fell(core_ok_in) && state_out == PCS_ST_USER && mon_user_en_in
    |-> ##[1:6] state_out == PCS_ST_MONITOR) else $error("no restart");
  a_cfg_from_mon: assert property (
    state_out == PCS_ST_CONFIG && $past(state_out) != PCS_ST_CONFIG
    |-> $past(state_out) inside {PCS_ST_MONITOR, PCS_ST_USER, PCS_ST_FAIL}) else $error("bad entry");
  a_io_held: assert property (
    state_out inside {PCS_ST_CONFIG, PCS_ST_CRC} |-> !io_user_out) else $error("I/O early");
  a_io_release: assert property ($rose(io_user_out) |-> state_out == PCS_ST_USER)
    else $error("I/O outside user");
  a_port_held: assert property (
    state_out == PCS_ST_CONFIG && $past(state_out) == PCS_ST_CONFIG |-> $stable(active_port_out))
    else $error("port moved");
  a_net_follow: assert property (
    state_out == PCS_ST_USER && $past(state_out) == PCS_ST_USER
    |-> clk_net_en_out == $past(clk_net_en_in)) else $error("net stuck");
  a_bank_follow: assert property (
    state_out == PCS_ST_USER && $past(state_out) == PCS_ST_USER && analog_out.ref_on
    |-> diff_bank_pwr_out == $past(diff_bank_en_in)) else $error("bank stuck");
  a_rb_locked: assert property (
    readback_req_in && locked_out |=> req_rejected_out && !readback_ok_out) else $error("readback");
  a_lock_sticky: assert property ($fell(locked_out) |-> $past(erase_req_in))
    else $error("lock cleared");
  a_otp_refuse: assert property (
    (erase_req_in || prog_req_in) && otp_out |=> req_rejected_out && !erase_ok_out && !prog_ok_out)
    else $error("one-time mode");
  c_standby: cover property (state_out == PCS_ST_STANDBY);
  c_reject: cover property (req_rejected_out);
  c_crc_fail: cover property (state_out == PCS_ST_FAIL);
endmodule
`default_nettype wire

// >>> dv/pcs_host_model.sv
// Model of the configuration master and the standby requester.
`timescale 1ns/100ps
`default_nettype none
module pcs_host_model (
  // Clock.
  input  wire logic sys_clk_in,
  // Configuration stream and test command.
  output logic      vld_out,
  output logic      bit_out,
  output logic      last_out,
  output logic      test_cmd_out,
  // Standby requests.
  output logic      tgl_out,
  output logic      i2c_cmd_out,
  output logic      test_sb_out
);
  initial begin
    {vld_out, bit_out, last_out, test_cmd_out, tgl_out, i2c_cmd_out, test_sb_out} = '0;
  end
  // MSB first; idle cycles show the inverse bit.
  task automatic send(input logic [15:0] w, input int gap);
    for (int i = 15; i >= 0; i--) begin
      @(negedge sys_clk_in);
      vld_out = 1'b1;
      bit_out = w[i];
      @(negedge sys_clk_in);
      vld_out = 1'b0;
      bit_out = ~w[i];
      repeat (gap) @(negedge sys_clk_in);
    end
  endtask
  task automatic finish();
    @(negedge sys_clk_in);
    last_out = 1'b1;
    @(negedge sys_clk_in);
    last_out = 1'b0;
  endtask
  task automatic test_cmd();
    @(negedge sys_clk_in);
    test_cmd_out = 1'b1;
    @(negedge sys_clk_in);
    test_cmd_out = 1'b0;
  endtask
  // Kind 0 toggles the level; 1 and 2 pulse a command.
  task automatic standby(input int k);
    @(negedge sys_clk_in);
    tgl_out = tgl_out ^ (k == 0);
    i2c_cmd_out = (k == 1);
    test_sb_out = (k == 2);
    @(negedge sys_clk_in);
    {i2c_cmd_out, test_sb_out} = '0;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_power_config_sequencer.sv
// Self-checking bench for the power and configuration sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defines.svh"
module tb_power_config_sequencer
  import pcs_pkg::*;
;
  typedef struct packed {
    logic osc; logic [1:0] pll; logic [3:0] bank; logic [7:0] net; logic [7:0] ibuf;
    logic exp_osc; logic [1:0] exp_pll;
  } pcs_row_t;
  logic sys_clk_in = 1'b0;
  logic rst_in, core_ok_in, cfgbank_ok_in, lp_det_ok_in, core_1v2_in, mon_user_en_in;
  logic crc_en_in, osc_unused_in, wake_in, sec_set_in, otp_set_in, erase_req_in;
  logic prog_req_in, readback_req_in, crc_err_out, io_user_out, locked_out, otp_out;
  logic readback_ok_out, erase_ok_out, prog_ok_out, req_rejected_out;
  wire logic cfg_bit_vld_in, cfg_bit_in, cfg_last_in, test_cmd_in;
  wire logic sb_req_tgl_in, sb_cmd_i2c_in, sb_cmd_test_in;
  logic [1:0] pll_unused_in, pll_clk_low_in, pll_pwr_out;
  logic [3:0] diff_bank_en_in, diff_bank_pwr_out;
  logic [7:0] clk_net_en_in, inbuf_en_in, inbuf_is_clk_in, clk_net_en_out, inbuf_en_out;
  logic [2:0] port_sel_in, active_port_out;
  logic [15:0] crc_exp_in;
  logic [9:0] dual_pin_gpio_out;
  pcs_sb_sel_t sb_sel_in;
  pcs_analog_t analog_out;
  pcs_state_t state_out;
  int miscompares, total_checks, cyc;
  pcs_row_t rows[4] = '{'{1'b0, 2'h0, 4'hF, 8'hFF, 8'hFF, 1'b1, 2'h3},
    '{1'b1, 2'h3, 4'h0, 8'h00, 8'h00, 1'b0, 2'h0}, '{1'b0, 2'h1, 4'h5, 8'hA5, 8'h3C, 1'b1, 2'h2},
    '{1'b0, 2'h2, 4'hA, 8'h5A, 8'hC3, 1'b1, 2'h1}};
  // Kind, lock after, {erase ok, prog ok, readback ok, rejected}.
  logic [7:0] ops[9] = '{8'h82, 8'h10, 8'h91, 8'h74, 8'h48, 8'h10, 8'h30, 8'h51, 8'h71};
  pcs_seq i_dut (.*);
  pcs_host_model i_host (.sys_clk_in, .vld_out(cfg_bit_vld_in), .bit_out(cfg_bit_in),
    .last_out(cfg_last_in), .test_cmd_out(test_cmd_in), .tgl_out(sb_req_tgl_in),
    .i2c_cmd_out(sb_cmd_i2c_in), .test_sb_out(sb_cmd_test_in));
  always #5 sys_clk_in = ~sys_clk_in;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Far above the run; trips only on a hang.
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic wait_st(input pcs_state_t s);
    int n = 0;
    while (state_out !== s && n < 400) begin
      tick(1);
      n++;
    end
    check(state_out, s);
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = `PCS_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `PCS_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic do_cfg(input logic [2:0] p, input logic [15:0] w, input logic good);
    port_sel_in = p;
    crc_exp_in = good ? crc16(w) : ~crc16(w);
    if (p == `PCS_SRC_TEST) i_host.test_cmd();
    wait_st(PCS_ST_CONFIG);
    check(io_user_out, 1'b0);
    check(active_port_out, p);
    check(dual_pin_gpio_out, 10'h000);
    port_sel_in = p ^ 3'h1;
    i_host.send(w, p);
    check(active_port_out, p);
    port_sel_in = p;
    i_host.finish();
    wait_st(good ? PCS_ST_USER : PCS_ST_FAIL);
    tick(1);
    check({io_user_out, crc_err_out}, {good, !good});
    if (good) check(dual_pin_gpio_out, 10'h3FF);
  endtask
  initial begin
    {rst_in, core_1v2_in, mon_user_en_in, crc_en_in, lp_det_ok_in} = '1;
    {core_ok_in, cfgbank_ok_in, osc_unused_in, wake_in, sec_set_in, otp_set_in} = '0;
    {erase_req_in, prog_req_in, readback_req_in, pll_unused_in, diff_bank_en_in} = '0;
    {clk_net_en_in, inbuf_en_in, port_sel_in, crc_exp_in} = '0;
    {sb_sel_in, pll_clk_low_in} = '1;
    inbuf_is_clk_in = 8'h0F;
    tick(20);
    check({state_out, analog_out, io_user_out, locked_out}, 10'h034);
    rst_in = 1'b0;
    {core_ok_in, cfgbank_ok_in} = 2'h3;
    for (int p = 0; p < 5; p++) begin
      do_cfg(p[2:0], 16'hA5C3 + 16'(p), 1'b1);
    end
    foreach (rows[i]) begin
      osc_unused_in = rows[i].osc;
      pll_unused_in = rows[i].pll;
      diff_bank_en_in = rows[i].bank;
      clk_net_en_in = rows[i].net;
      inbuf_en_in = rows[i].ibuf;
      tick(4);
      check(analog_out.osc_on, rows[i].exp_osc);
      check(pll_pwr_out, rows[i].exp_pll);
      check(diff_bank_pwr_out, rows[i].bank);
      check(clk_net_en_out, rows[i].net);
      check(inbuf_en_out, rows[i].ibuf);
    end
    foreach (ops[i]) begin
      {sec_set_in, otp_set_in, erase_req_in, prog_req_in, readback_req_in} = 5'h10 >> ops[i][7:5];
      tick(1);
      {sec_set_in, otp_set_in, erase_req_in, prog_req_in, readback_req_in} = '0;
      check({erase_ok_out, prog_ok_out, readback_ok_out, req_rejected_out}, ops[i][3:0]);
      check(locked_out, ops[i][4]);
    end
    check(otp_out, 1'b1);
    for (int k = 0; k < 3; k++) begin
      core_1v2_in = (k == 0);
      tick(3);
      i_host.standby(k);
      wait_st(PCS_ST_STANDBY);
      check(analog_out.ref_on, k != 0);
      if (k == 0) begin
        check({analog_out, pll_pwr_out, diff_bank_pwr_out}, 10'h080);
        check(inbuf_en_out & inbuf_is_clk_in, 8'h00);
      end
      wake_in = 1'b1;
      wait_st(PCS_ST_USER);
      wake_in = 1'b0;
      tick(2);
      check({analog_out, pll_pwr_out, diff_bank_pwr_out}, 10'h35A);
    end
    core_ok_in = 1'b0;
    wait_st(PCS_ST_MONITOR);
    tick(1);
    check(io_user_out, 1'b0);
    check(state_out, PCS_ST_MONITOR);
    core_ok_in = 1'b1;
    do_cfg(`PCS_SRC_NV, 16'h1234, 1'b0);
    rst_in = 1'b1;
    tick(2);
    check({state_out, io_user_out, locked_out, otp_out}, 7'h00);
    rst_in = 1'b0;
    tick(1);
    check(state_out, PCS_ST_MONITOR);
    give_verdict();
  end
endmodule
bind pcs_seq pcs_seq_monitor #(.BANKS(BANKS), .NETS(NETS), .PLLS(PLLS)) i_mon (.sys_clk_in,
  .rst_in, .core_ok_in, .core_1v2_in, .mon_user_en_in, .diff_bank_en_in, .clk_net_en_in,
  .erase_req_in, .prog_req_in, .readback_req_in, .analog_out, .pll_pwr_out, .diff_bank_pwr_out,
  .clk_net_en_out, .state_out, .active_port_out, .io_user_out, .locked_out, .otp_out,
  .readback_ok_out, .erase_ok_out, .prog_ok_out, .req_rejected_out);
`default_nettype wire
